// ---- arq_pkg.sv ----
// Package with register map, field positions and entry type of the result queue.
package arq_pkg;
  localparam int ARQ_NUM_CONV = 5;
  localparam int ARQ_RESULT_W = 16;
  localparam int ARQ_DEPTH = 16;

  localparam logic [7:0] ARQ_OFF_STATUS = 8'h00;
  localparam logic [7:0] ARQ_OFF_DATA = 8'h04;
  localparam logic [7:0] ARQ_OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] ARQ_OFF_IRQ_MASK = 8'h0C;

  localparam int ARQ_BIT_ENABLE = 31;
  localparam int ARQ_BIT_CONV_LO = 24;
  localparam int ARQ_BIT_IRQ_EN = 23;
  localparam int ARQ_BIT_READY = 22;
  localparam int ARQ_BIT_OVF = 21;
  localparam int ARQ_BIT_CNT_LO = 8;
  localparam int ARQ_BIT_SIGN = 7;
  localparam int ARQ_BIT_ID_LO = 0;

  localparam int ARQ_EV_READY = 0;
  localparam int ARQ_EV_OVF = 1;
  localparam int ARQ_EV_W = 2;

  localparam logic [31:0] ARQ_STATUS_RESET = 32'h0000_0000;

  typedef struct packed {
    logic is_signed;
    logic [2:0] src;
    logic [ARQ_RESULT_W-1:0] value;
  } arq_entry_t;

  localparam int ARQ_ENTRY_W = $bits(arq_entry_t);
endpackage : arq_pkg

// ---- arq_entry_ram.sv ----
// Entry storage of the result queue with a registered read port.
`timescale 1ns/10ps
module arq_entry_ram #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 20,
  parameter int AW = 4
) (
  input wire logic pclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // A write to the address being read passes straight through, so a fresh head shows at once.
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= (we && waddr == raddr) ? wdata : mem[raddr];
  end
endmodule : arq_entry_ram

// ---- arq_result_queue.sv ----
// Shared converter result queue with its APB status, data and interrupt registers.
//
// The address map and register access over APB were decided locally.
`timescale 1ns/10ps
module arq_result_queue
  import arq_pkg::*;
#(
  parameter int DEPTH = ARQ_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [ARQ_NUM_CONV-1:0] conv_valid,
  input wire logic [ARQ_NUM_CONV-1:0][ARQ_RESULT_W-1:0] conv_result,
  input wire logic [ARQ_NUM_CONV-1:0] conv_signed,
  output logic [ARQ_NUM_CONV-1:0][ARQ_RESULT_W-1:0] converter_result_reg,
  output logic irq
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || DEPTH > 255) begin
      $error("DEPTH must lie between 2 and 255");
    end
    // The source identifier is three bits wide and codes 5 to 7 stay unused.
    if (ARQ_NUM_CONV < 1 || ARQ_NUM_CONV > 5) begin
      $error("ARQ_NUM_CONV must lie between 1 and 5");
    end
    // The head value is presented in one 32-bit data word.
    if (ARQ_RESULT_W < 1 || ARQ_RESULT_W > 32) begin
      $error("ARQ_RESULT_W must lie between 1 and 32");
    end
  end

  logic queue_enable;
  logic [ARQ_NUM_CONV-1:0] converter_capture_enables;
  logic queue_irq_enable;
  logic queue_overflow_error;
  logic [7:0] queue_entry_count;
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [ARQ_NUM_CONV-1:0] pending;
  arq_entry_t [ARQ_NUM_CONV-1:0] pend_entry;
  logic [ARQ_EV_W-1:0] irq_status;
  logic [ARQ_EV_W-1:0] irq_mask;
  logic ack;
  logic ready_q;
  logic [ARQ_ENTRY_W-1:0] head_raw;

  // APB decode: every access waits one cycle in the access phase for registered read data.
  wire logic access = psel && penable;
  wire logic done = access && ack;
  wire logic hit_status = paddr == ARQ_OFF_STATUS;
  wire logic hit_data = paddr == ARQ_OFF_DATA;
  wire logic hit_istat = paddr == ARQ_OFF_IRQ_STAT;
  wire logic hit_imask = paddr == ARQ_OFF_IRQ_MASK;
  wire logic hit_any = hit_status || hit_data || hit_istat || hit_imask;
  wire logic wr_done = done && pwrite;
  wire logic rd_done = done && !pwrite;

  // Queue state and the head entry.
  wire logic queue_empty = queue_entry_count == 8'h00;
  wire logic queue_full = queue_entry_count == 8'(DEPTH);
  wire logic queue_data_ready = !queue_empty;
  wire arq_entry_t head = arq_entry_t'(head_raw);
  wire logic head_entry_signed = queue_data_ready && head.is_signed;
  // Sign and source fields read zero while the queue is empty, so stale RAM contents never show.
  // The RAM keeps its old word after the last pop, which is why the fields are gated here.
  wire logic [2:0] head_entry_source_id = queue_data_ready ? head.src : 3'h0;
  wire logic pop = rd_done && hit_data && queue_data_ready;

  // One pending converter result enters per cycle, lowest converter number first.
  logic [ARQ_NUM_CONV-1:0] grant;
  always_comb begin
    grant = '0;
    for (int i = ARQ_NUM_CONV - 1; i >= 0; i--) begin
      if (pending[i]) begin
        grant = '0;
        grant[i] = 1'b1;
      end
    end
  end
  wire logic offer = |grant;
  arq_entry_t push_entry;
  always_comb begin
    push_entry = '0;
    for (int i = 0; i < ARQ_NUM_CONV; i++) begin
      if (grant[i]) begin
        push_entry = pend_entry[i];
      end
    end
  end
  wire logic push = offer && queue_enable && !queue_full;
  wire logic overflow_event = offer && queue_enable && queue_full;
  wire logic ready_event = queue_data_ready && !ready_q;

  // Capture of converter results into their own registers and into pending slots.
  wire logic [ARQ_NUM_CONV-1:0] capture = conv_valid & converter_capture_enables
                                         & {ARQ_NUM_CONV{queue_enable}};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_result_reg <= '0;
      pending <= '0;
      pend_entry <= '0;
    end else begin
      for (int i = 0; i < ARQ_NUM_CONV; i++) begin
        if (conv_valid[i]) begin
          converter_result_reg[i] <= conv_result[i];
        end
        if (capture[i]) begin
          pending[i] <= 1'b1;
          pend_entry[i] <= '{is_signed: conv_signed[i], src: 3'(i),
                             value: conv_result[i]};
        end else if (grant[i] || !queue_enable) begin
          pending[i] <= 1'b0;
        end
      end
    end
  end

  // Pointers wrap at the last entry, because DEPTH need not be a power of two.
  // A push and a pop in one cycle leave the count unchanged.
  wire logic [AW-1:0] wr_ptr_inc = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
  wire logic [AW-1:0] rd_ptr_inc = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
  wire logic [AW-1:0] next_wr_ptr = push ? wr_ptr_inc : wr_ptr;
  wire logic [AW-1:0] next_rd_ptr = pop ? rd_ptr_inc : rd_ptr;
  wire logic count_up = push && !pop;
  wire logic count_down = pop && !push;
  wire logic [7:0] next_count = count_up ? queue_entry_count + 8'h01 :
                                count_down ? queue_entry_count - 8'h01 :
                                queue_entry_count;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      queue_entry_count <= 8'h00;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      queue_entry_count <= next_count;
    end
  end

  // The read address looks one entry ahead on a pop, so the new head is ready next cycle.

  arq_entry_ram #(
    .DEPTH(DEPTH),
    .WIDTH(ARQ_ENTRY_W),
    .AW(AW)
  ) u_ram (
    .pclk(pclk),
    .we(push),
    .waddr(wr_ptr),
    .wdata(push_entry),
    .raddr(next_rd_ptr),
    .rdata(head_raw)
  );

  // Control fields; only the documented writable bits take a write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      queue_enable <= ARQ_STATUS_RESET[ARQ_BIT_ENABLE];
      converter_capture_enables <= ARQ_STATUS_RESET[ARQ_BIT_CONV_LO +: ARQ_NUM_CONV];
      queue_irq_enable <= ARQ_STATUS_RESET[ARQ_BIT_IRQ_EN];
      irq_mask <= '0;
    end else if (wr_done) begin
      if (hit_status) begin
        queue_enable <= pwdata[ARQ_BIT_ENABLE];
        converter_capture_enables <= pwdata[ARQ_BIT_CONV_LO +: ARQ_NUM_CONV];
        queue_irq_enable <= pwdata[ARQ_BIT_IRQ_EN];
      end
      if (hit_imask) begin
        irq_mask <= pwdata[ARQ_EV_W-1:0];
      end
    end
  end

  // Overflow flag and sticky event bits; a new event wins over a clear in the same cycle.
  wire logic ovf_clear = rd_done && hit_status;
  wire logic [ARQ_EV_W-1:0] ev_set = {overflow_event, ready_event};
  wire logic [ARQ_EV_W-1:0] ev_clr = (wr_done && hit_istat) ? pwdata[ARQ_EV_W-1:0] : '0;
  // A dropped result keeps the flag set even when software reads the status in that cycle.
  wire logic ovf_hold = queue_overflow_error && !ovf_clear;
  wire logic next_overflow_error = overflow_event || ovf_hold;
  wire logic [ARQ_EV_W-1:0] next_irq_status = ev_set | (irq_status & ~ev_clr);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      queue_overflow_error <= 1'b0;
      irq_status <= '0;
      ready_q <= 1'b0;
    end else begin
      queue_overflow_error <= next_overflow_error;
      irq_status <= next_irq_status;
      ready_q <= queue_data_ready;
    end
  end

  // Interrupt: the enabled data-ready level, or any unmasked sticky event.
  // It is registered, so it follows its sources one cycle later but never glitches.
  wire logic irq_level = queue_irq_enable && queue_data_ready;
  wire logic irq_sticky = |(irq_status & irq_mask);
  wire logic next_irq = irq_level || irq_sticky;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // Status word; unlisted bits stay zero.
  logic [31:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[ARQ_BIT_ENABLE] = queue_enable;
    status_word[ARQ_BIT_CONV_LO +: ARQ_NUM_CONV] = converter_capture_enables;
    status_word[ARQ_BIT_IRQ_EN] = queue_irq_enable;
    status_word[ARQ_BIT_READY] = queue_data_ready;
    status_word[ARQ_BIT_OVF] = queue_overflow_error;
    status_word[ARQ_BIT_CNT_LO +: 8] = queue_entry_count;
    status_word[ARQ_BIT_SIGN] = head_entry_signed;
    status_word[ARQ_BIT_ID_LO +: 3] = head_entry_source_id;
  end

  wire logic [31:0] queue_output_data = queue_data_ready ? 32'(head.value) : 32'h0000_0000;
  wire logic [31:0] read_mux = hit_status ? status_word :
                               hit_data ? queue_output_data :
                               hit_istat ? 32'(irq_status) :
                               hit_imask ? 32'(irq_mask) : 32'h0000_0000;

  // Access phase tracker: the first access cycle loads read data, the second answers.
  typedef enum logic [1:0] {
    ARQ_ST_LOAD = 2'b01,
    ARQ_ST_ANSWER = 2'b10
  } arq_bus_state_t;
  arq_bus_state_t bus_state;
  arq_bus_state_t next_bus_state;
  always_comb begin
    case (bus_state)
      ARQ_ST_LOAD: begin
        next_bus_state = access ? ARQ_ST_ANSWER : ARQ_ST_LOAD;
      end
      ARQ_ST_ANSWER: begin
        next_bus_state = ARQ_ST_LOAD;
      end
      default: begin
        next_bus_state = ARQ_ST_LOAD;
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_state <= ARQ_ST_LOAD;
    end else begin
      bus_state <= next_bus_state;
    end
  end
  assign ack = bus_state == ARQ_ST_ANSWER;
  wire logic load = access && !ack;

  // Read data and the answer are prepared in the first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      if (load) begin
        prdata <= pwrite ? 32'h0000_0000 : read_mux;
        pslverr <= !hit_any;
      end else if (!access) begin
        pslverr <= 1'b0;
      end
    end
  end

  assign pready = done;
endmodule : arq_result_queue

// ---- arq_result_queue_checker.sv ----
// Checker of the result queue port behaviour.
`timescale 1ns/10ps
module arq_result_queue_checker
  import arq_pkg::*;
#(parameter int DEPTH = ARQ_DEPTH) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [ARQ_NUM_CONV-1:0] conv_valid,
  input wire logic [ARQ_NUM_CONV-1:0][ARQ_RESULT_W-1:0] conv_result,
  input wire logic [ARQ_NUM_CONV-1:0] conv_signed,
  input wire logic [ARQ_NUM_CONV-1:0][ARQ_RESULT_W-1:0] converter_result_reg,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire done = psel && penable && pready;
  wire rd_st = done && !pwrite && paddr == ARQ_OFF_STATUS;
  wire wr_st = done && pwrite && paddr == ARQ_OFF_STATUS;
  wire wr_mk = done && pwrite && paddr == ARQ_OFF_IRQ_MASK;
  logic ien;
  logic [1:0] msk;
  // Shadows of the interrupt enable and mask, as written by software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien <= 1'b0;
      msk <= 2'h0;
    end else begin
      if (wr_st) ien <= pwdata[23];
      if (wr_mk) msk <= pwdata[1:0];
    end
  end
  property p_rsv; rd_st |-> prdata[30:29] == 2'h0 && prdata[6:3] == 4'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_id; rd_st |-> prdata[2:0] < 3'h5; endproperty
  a_id: assert property (p_id) else $error("bad source id");
  property p_cnt; rd_st |-> prdata[22] == (prdata[15:8] != 8'h00) && prdata[15:8] <= DEPTH;
  endproperty
  a_cnt: assert property (p_cnt) else $error("ready or count wrong");
  property p_head; rd_st && prdata[15:8] == 8'h00 |-> prdata[7] == 1'b0 && prdata[2:0] == 3'h0;
  endproperty
  a_head: assert property (p_head) else $error("head fields while empty");
  property p_res0; conv_valid[0] |=> converter_result_reg[0] == $past(conv_result[0]); endproperty
  a_res0: assert property (p_res0) else $error("result reg 0 wrong");
  property p_res4; conv_valid[4] ##1 !conv_valid[4] |=> converter_result_reg[4] == $past(conv_result[4], 2);
  endproperty
  a_res4: assert property (p_res4) else $error("result reg 4 wrong");
  property p_irq_off; (ien == 1'b0 && msk == 2'h0) [*2] |-> !irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
  property p_irq_on; ien && rd_st && prdata[22] |-> ##[0:2] irq; endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing");
  c_ovf: cover property (rd_st && prdata[21]);
  c_irq: cover property (irq);
  c_err: cover property (done && pslverr);
endmodule : arq_result_queue_checker
bind arq_result_queue arq_result_queue_checker #(.DEPTH(DEPTH)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .conv_valid(conv_valid), .conv_result(conv_result), .conv_signed(conv_signed),
  .converter_result_reg(converter_result_reg));

// ---- arq_conv_model.sv ----
// Converter core stand-in that hands results to the queue.
`timescale 1ns/10ps
module arq_conv_model
  import arq_pkg::*;
(
  input wire logic pclk,
  output logic [ARQ_NUM_CONV-1:0] conv_valid,
  output logic [ARQ_NUM_CONV-1:0][ARQ_RESULT_W-1:0] conv_result,
  output logic [ARQ_NUM_CONV-1:0] conv_signed
);
  initial begin
    conv_valid = '0;
    conv_result = '0;
    conv_signed = '0;
  end
  // After the valid cycle the lines carry the inverse, so a late sample shows.
  task send(input logic [2:0] i, input logic [15:0] v, input logic s);
    @(posedge pclk);
    conv_valid[i] <= 1'b1;
    conv_result[i] <= v;
    conv_signed[i] <= s;
    @(posedge pclk);
    conv_valid[i] <= 1'b0;
    conv_result[i] <= ~v;
    conv_signed[i] <= ~s;
  endtask : send
endmodule : arq_conv_model

// ---- arq_result_queue_tb_top.sv ----
// Self-checking bench of the result queue.
`timescale 1ns/10ps
module arq_result_queue_tb_top;
  import arq_pkg::*;
  typedef struct {logic [2:0] src; logic [15:0] val; logic sgn;} arq_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [ARQ_NUM_CONV-1:0] cv, cs;
  logic [ARQ_NUM_CONV-1:0][ARQ_RESULT_W-1:0] cr, creg;
  int fail_count, n_compared;
  arq_row_t rows [5] = '{'{3'h0, 16'h1234, 1'b0}, '{3'h1, 16'h8001, 1'b1},
    '{3'h4, 16'hFFFF, 1'b1}, '{3'h2, 16'h0000, 1'b0}, '{3'h3, 16'h5A5A, 1'b1}};
  arq_result_queue #(.DEPTH(2)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_valid(cv), .conv_result(cr),
    .conv_signed(cs), .converter_result_reg(creg), .irq(irq));
  arq_conv_model conv (.pclk(pclk), .conv_valid(cv), .conv_result(cr), .conv_signed(cs));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      final_report();
    end
  endtask : apb
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    fail_count = 0;
    n_compared = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ARQ_OFF_STATUS, 0); chk(r, ARQ_STATUS_RESET);
    chk(e, 0);
    apb(1, ARQ_OFF_STATUS, 32'hFFFF_FFFF); apb(0, ARQ_OFF_STATUS, 0); chk(r, 32'h9F80_0000);
    apb(1, ARQ_OFF_STATUS, 32'h9F00_0000);
    foreach (rows[k]) begin
      conv.send(rows[k].src, rows[k].val, rows[k].sgn);
      apb(0, ARQ_OFF_STATUS, 0);
      chk(r, 32'h9F40_0100 | {rows[k].sgn, 4'h0, rows[k].src});
      chk(creg[rows[k].src], rows[k].val);
      apb(0, ARQ_OFF_DATA, 0); chk(r, {16'h0, rows[k].val});
      apb(0, ARQ_OFF_STATUS, 0); chk(r, 32'h9F00_0000);
    end
    apb(1, ARQ_OFF_STATUS, 32'h0F00_0000); conv.send(1, 16'h0101, 0);
    apb(0, ARQ_OFF_STATUS, 0); chk(r, 32'h0F00_0000);
    apb(1, ARQ_OFF_STATUS, 32'h8100_0000); conv.send(3, 16'h3333, 0);
    apb(0, ARQ_OFF_STATUS, 0); chk(r, 32'h8100_0000);
    chk(creg[3], 16'h3333);
    apb(1, ARQ_OFF_STATUS, 32'h8180_0000);
    repeat (3) conv.send(0, 16'h00A5, 0);
    apb(0, ARQ_OFF_STATUS, 0); chk(r, 32'h81E0_0200);
    @(negedge pclk); chk(irq, 1);
    apb(0, ARQ_OFF_STATUS, 0); chk(r, 32'h81C0_0200);
    repeat (2) apb(0, ARQ_OFF_DATA, 0);
    apb(0, ARQ_OFF_STATUS, 0); chk(r, 32'h8180_0000);
    repeat (2) @(negedge pclk); chk(irq, 0);
    apb(1, ARQ_OFF_IRQ_MASK, 2); repeat (2) @(negedge pclk); chk(irq, 1);
    apb(0, ARQ_OFF_IRQ_STAT, 0); chk(r, 3);
    apb(1, ARQ_OFF_IRQ_STAT, 3); repeat (2) @(negedge pclk); chk(irq, 0);
    apb(0, 8'h10, 0); chk(e, 1); chk(r, 0);
    conv.send(0, 16'h0042, 0);
    @(posedge pclk); presetn <= 1'b0;
    @(posedge pclk); presetn <= 1'b1;
    apb(0, ARQ_OFF_STATUS, 0); chk(r, ARQ_STATUS_RESET);
    final_report();
  end
endmodule : arq_result_queue_tb_top
